//--- rtl/stop_recovery_pkg.sv
package stop_recovery_pkg;

	// ----------------------------------------------------------------
	// Register map (word indices and byte addresses)
	// ----------------------------------------------------------------
	localparam logic [3:0] stop_recovery_control_idx = 4'hB;
	localparam logic [3:0] first_port_wake_select_idx = 4'h1;
	localparam logic [11:0] stop_recovery_control_addr = 12'h02C;
	localparam logic [11:0] first_port_wake_select_addr = 12'h004;
	localparam logic [11:0] second_port_wake_select_addr = 12'h008;
	localparam logic [11:0] irq_status_addr = 12'h010;
	localparam logic [11:0] irq_mask_addr = 12'h014;
	localparam logic [11:0] power_control_addr = 12'h018;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int stop_flag_bit = 7;
	localparam int stop_delay_bit = 5;
	localparam int enter_stop_bit = 0;
	localparam int enter_halt_bit = 1;
	localparam int irq_wake_bit = 0;
	localparam int irq_cold_bit = 1;

	// ----------------------------------------------------------------
	// Reset values, read-back constants and divide-select codes
	// ----------------------------------------------------------------
	localparam logic [7:0] wake_select_reset = 8'h00;
	localparam logic stop_delay_reset = 1'b1;
	localparam logic [1:0] divide_select_reset = 2'h0;
	localparam logic [7:0] recovery_readback = 8'h7F;
	localparam logic [1:0] divide_by_16_code = 2'h3;
	localparam logic [1:0] divide_by_8_code = 2'h2;
	localparam logic [1:0] divide_by_32_code = 2'h1;
	localparam logic [1:0] divide_by_2_code = 2'h0;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int clock_period_ns = 100;
	localparam int wake_delay_ms = 5;
	localparam int wake_delay_cycles = wake_delay_ms * 1000000 / clock_period_ns;

	typedef enum logic [1:0] {run_st, stop_st, delay_st} power_state_t;

endpackage

//--- rtl/clock_divider.sv
`timescale 1ns/1ps
`default_nettype none

// Produces one-cycle enables at the selected crystal divide ratio.
module clock_divider
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [1:0] divide_select,
	input wire logic run,
	output logic tick
);

	logic [4:0] count_ff;
	logic [4:0] limit;

	always_comb
	begin
		unique case (divide_select)
			stop_recovery_pkg::divide_by_16_code: limit = 5'h0F;
			stop_recovery_pkg::divide_by_8_code: limit = 5'h07;
			stop_recovery_pkg::divide_by_32_code: limit = 5'h1F;
			stop_recovery_pkg::divide_by_2_code: limit = 5'h01;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			count_ff <= 5'h00;
		else if (!run || count_ff >= limit)
			count_ff <= 5'h00;
		else
			count_ff <= count_ff + 5'h01;
	end

	assign tick = run && (count_ff == limit);

endmodule
`default_nettype wire

//--- rtl/stop_recovery.sv
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Sixteen pins on two ports can wake.
// - Any pin combination, one select register per port.
// - Latch selected pin levels, wake on change.
// - Comparator never wakes; off during stop.
// - Stop flag bit 7 set on stop entry, read-only.
// - Flag reads 1 warm, 0 cold.
// - Bits 1:0 pick divide 16/8/32/2, read 11.
// - Processor divide in run, timer divide outside stop.
// - Halt keeps timers on timer clock.
// - Select bits: 1 source, 0 not, reset 0.
module stop_recovery
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [7:0] first_port_pins,
	input wire logic [7:0] second_port_pins,
	input wire logic watchdog_reset,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic cpu_clock_tick,
	output logic timer_interrupt_clock,
	output logic comparator_enable,
	output logic device_reset,
	output logic in_stop,
	output logic irq
);

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	logic wr_pend_ff;
	logic in_stop_ff;
	logic [11:0] addr_ff;
	logic [7:0] first_sel_ff;
	logic [7:0] second_sel_ff;
	logic stop_delay_ff;
	logic [1:0] divide_ff;
	logic stop_flag_ff;
	logic [1:0] irq_status_ff;
	logic [1:0] irq_mask_ff;
	logic [7:0] first_latch_ff;
	logic [7:0] second_latch_ff;
	logic [22:0] delay_count_ff;
	logic halt_ff;
	logic [31:0] hrdata_ff;
	logic irq_ff;
	logic cpu_tick_ff;
	logic timer_tick_ff;
	logic comparator_ff;
	logic device_reset_ff;
	stop_recovery_pkg::power_state_t state_ff;
	logic addr_phase;
	logic wr_en;
	logic rd_en;
	logic stop_request;
	logic halt_request;
	logic wake;
	logic status_read;
	logic div_tick;
	logic wake_event;
	logic cold_event;

	localparam logic [22:0] delay_last = 23'(stop_recovery_pkg::wake_delay_cycles - 1);

	assign addr_phase = hsel && hready && htrans[1];
	assign wr_en = wr_pend_ff;
	assign rd_en = addr_phase && !hwrite;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_ff <= 1'b0;
			addr_ff <= 12'h000;
		end
		else
		begin
			wr_pend_ff <= addr_phase && hwrite;
			if (addr_phase)
				addr_ff <= haddr[11:0];
		end
	end

	// Read data is registered at the address phase, so every transfer ends with no wait state.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata_ff <= 32'h00000000;
		else if (rd_en)
		begin
			unique case (haddr[11:0])
				stop_recovery_pkg::stop_recovery_control_addr:
					hrdata_ff <= {24'h000000, stop_flag_ff,
						stop_recovery_pkg::recovery_readback[6:0]};
				stop_recovery_pkg::first_port_wake_select_addr:
					hrdata_ff <= {24'h000000, first_sel_ff};
				stop_recovery_pkg::second_port_wake_select_addr:
					hrdata_ff <= {24'h000000, second_sel_ff};
				stop_recovery_pkg::irq_status_addr:
					hrdata_ff <= {30'h00000000, irq_status_ff};
				stop_recovery_pkg::irq_mask_addr:
					hrdata_ff <= {30'h00000000, irq_mask_ff};
				stop_recovery_pkg::power_control_addr:
					hrdata_ff <= {30'h00000000, halt_ff, in_stop};
				default:
					hrdata_ff <= 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			first_sel_ff <= stop_recovery_pkg::wake_select_reset;
			second_sel_ff <= stop_recovery_pkg::wake_select_reset;
			stop_delay_ff <= stop_recovery_pkg::stop_delay_reset;
			divide_ff <= stop_recovery_pkg::divide_select_reset;
			irq_mask_ff <= 2'h0;
		end
		else if (wr_en)
		begin
			unique case (addr_ff)
				stop_recovery_pkg::stop_recovery_control_addr:
				begin
					// Bit 7 is not written: the flag belongs to the hardware alone.
					stop_delay_ff <= hwdata[stop_recovery_pkg::stop_delay_bit];
					divide_ff <= hwdata[1:0];
				end
				stop_recovery_pkg::first_port_wake_select_addr:
					first_sel_ff <= hwdata[7:0];
				stop_recovery_pkg::second_port_wake_select_addr:
					second_sel_ff <= hwdata[7:0];
				stop_recovery_pkg::irq_mask_addr:
					irq_mask_ff <= hwdata[1:0];
				default:
				begin
				end
			endcase
		end
	end

	assign stop_request = wr_en && (addr_ff == stop_recovery_pkg::power_control_addr)
		&& hwdata[stop_recovery_pkg::enter_stop_bit];
	assign halt_request = wr_en && (addr_ff == stop_recovery_pkg::power_control_addr)
		&& hwdata[stop_recovery_pkg::enter_halt_bit];

	// ----------------------------------------------------------------
	// Stop, wake and delay sequencing
	// ----------------------------------------------------------------
	// A change on any selected pin against its latched level ends stop.
	assign wake = (state_ff == stop_recovery_pkg::stop_st) &&
		(|((first_port_pins ^ first_latch_ff) & first_sel_ff) ||
		|((second_port_pins ^ second_latch_ff) & second_sel_ff));

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			first_latch_ff <= 8'h00;
			second_latch_ff <= 8'h00;
		end
		else if (stop_request && state_ff == stop_recovery_pkg::run_st)
		begin
			first_latch_ff <= first_port_pins;
			second_latch_ff <= second_port_pins;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_ff <= stop_recovery_pkg::run_st;
			delay_count_ff <= 23'h000000;
		end
		else
		begin
			unique case (state_ff)
				stop_recovery_pkg::run_st:
					if (stop_request)
						state_ff <= stop_recovery_pkg::stop_st;
				stop_recovery_pkg::stop_st:
					if (wake && stop_delay_ff)
					begin
						state_ff <= stop_recovery_pkg::delay_st;
						delay_count_ff <= 23'h000000;
					end
					else if (wake)
						state_ff <= stop_recovery_pkg::run_st;
				stop_recovery_pkg::delay_st:
					if (delay_count_ff == delay_last)
						state_ff <= stop_recovery_pkg::run_st;
					else
						delay_count_ff <= delay_count_ff + 23'h000001;
			endcase
		end
	end

	// Mirrors the next state so the stop pin is a plain flip-flop output.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			in_stop_ff <= 1'b0;
		else
			in_stop_ff <= (state_ff == stop_recovery_pkg::run_st && stop_request)
				|| (state_ff == stop_recovery_pkg::stop_st && !wake);
	end

	// Watchdog is a cold start, so it clears the flag like power-on.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			stop_flag_ff <= 1'b0;
		else if (watchdog_reset)
			stop_flag_ff <= 1'b0;
		else if (stop_request && state_ff == stop_recovery_pkg::run_st)
			stop_flag_ff <= 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			halt_ff <= 1'b0;
		else if (halt_request)
			halt_ff <= 1'b1;
		else if (irq_ff || wake_event)
			halt_ff <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Clock division
	// ----------------------------------------------------------------
	// One divider serves both clocks since they share the ratio; the
	// processor gate is applied on the output only.
	clock_divider u_divider
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.divide_select(divide_ff),
		.run(state_ff != stop_recovery_pkg::stop_st),
		.tick(div_tick)
	);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cpu_tick_ff <= 1'b0;
			timer_tick_ff <= 1'b0;
		end
		else
		begin
			cpu_tick_ff <= div_tick && !halt_ff
				&& state_ff == stop_recovery_pkg::run_st;
			timer_tick_ff <= div_tick;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			comparator_ff <= 1'b0;
			device_reset_ff <= 1'b0;
		end
		else
		begin
			comparator_ff <= state_ff == stop_recovery_pkg::run_st;
			device_reset_ff <= state_ff == stop_recovery_pkg::delay_st;
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	assign wake_event = wake;
	assign cold_event = watchdog_reset;
	// Clear on the edge that samples the read data, so no event falls between the two.
	assign status_read = rd_en && haddr[11:0] == stop_recovery_pkg::irq_status_addr;

	// A new event in the clearing cycle is kept: set beats clear.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq_status_ff <= 2'h0;
		else
			irq_status_ff <= (status_read ? 2'h0 : irq_status_ff) | {cold_event, wake_event};
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq_ff <= 1'b0;
		else
			irq_ff <= |(((status_read ? 2'h0 : irq_status_ff) | {cold_event, wake_event})
				& irq_mask_ff);
	end

	assign hrdata = hrdata_ff;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign cpu_clock_tick = cpu_tick_ff;
	assign timer_interrupt_clock = timer_tick_ff;
	assign comparator_enable = comparator_ff;
	assign device_reset = device_reset_ff;
	assign in_stop = in_stop_ff;
	assign irq = irq_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	stop_flag_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(stop_request && state_ff == stop_recovery_pkg::run_st && !watchdog_reset)
		|=> stop_flag_ff)
		else $error("stop flag not set on stop entry");
	cold_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
		watchdog_reset |=> !stop_flag_ff)
		else $error("stop flag not cleared by watchdog");
	wake_exit_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(wake && !stop_delay_ff) |=> state_ff == stop_recovery_pkg::run_st)
		else $error("wake did not end stop");
	wake_delay_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(wake && stop_delay_ff) |=> state_ff == stop_recovery_pkg::delay_st ##1 device_reset_ff)
		else $error("reset delay not entered");
	no_false_wake_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_ff == stop_recovery_pkg::stop_st && first_port_pins == first_latch_ff
		&& second_port_pins == second_latch_ff) |-> !wake)
		else $error("wake without pin change");
	comp_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
		in_stop |=> !comparator_ff)
		else $error("comparator on during stop");
	halt_timer_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(halt_ff && div_tick) |=> timer_tick_ff && !cpu_tick_ff)
		else $error("timer clock lost in halt");
	select_apply_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_en && addr_ff == stop_recovery_pkg::first_port_wake_select_addr)
		|=> first_sel_ff == $past(hwdata[7:0]))
		else $error("select register not written");
	readback_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(rd_en && haddr[11:0] == stop_recovery_pkg::stop_recovery_control_addr)
		|=> hrdata_ff[6:0] == 7'h7F)
		else $error("control readback wrong");

endmodule
`default_nettype wire

//--- dv/wake_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Wake pins on the two ports
// ----------------------------------------------------------------
// Pins only move when the bench asks. A stray edge here would wake
// the block on its own.
module wake_pin_model
(
	input wire logic hclk,
	input wire logic fire,
	input wire logic [15:0] flip_mask,
	output logic [7:0] first_port_pins,
	output logic [7:0] second_port_pins
);
	logic [15:0] pins_ff = 16'hA55A;

	always_ff @(posedge hclk)
	begin
		if (fire)
			pins_ff <= pins_ff ^ flip_mask;
	end

	assign first_port_pins = pins_ff[7:0];
	assign second_port_pins = pins_ff[15:8];
endmodule

`default_nettype wire

//--- dv/stop_recovery_tb.sv
`timescale 1ns/1ps
`default_nettype none

module stop_recovery_tb;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic watchdog_reset = 1'b0;
	logic fire = 1'b0;
	logic [15:0] flip_mask = 16'h0;
	logic [7:0] first_port_pins, second_port_pins;
	logic [31:0] hrdata, q;
	logic hreadyout, hresp, cpu_clock_tick, timer_interrupt_clock;
	logic comparator_enable, device_reset, in_stop, irq;
	int n_errors = 0;
	int cmp_count = 0;
	int n;

	always #50 hclk = ~hclk;

	stop_recovery u_stop_recovery (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .first_port_pins(first_port_pins),
		.second_port_pins(second_port_pins), .watchdog_reset(watchdog_reset),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.cpu_clock_tick(cpu_clock_tick), .timer_interrupt_clock(timer_interrupt_clock),
		.comparator_enable(comparator_enable), .device_reset(device_reset),
		.in_stop(in_stop), .irq(irq));

	wake_pin_model u_wake_pin_model (.hclk(hclk), .fire(fire), .flip_mask(flip_mask),
		.first_port_pins(first_port_pins), .second_port_pins(second_port_pins));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask

	task toggle(input logic [15:0] m);
		@(posedge hclk);
		flip_mask <= m;
		fire <= 1'b1;
		@(posedge hclk);
		fire <= 1'b0;
		repeat (4) @(posedge hclk);
	endtask

	// Counts cycles between two ticks; the first tick only aligns us.
	task gap(input logic tmr);
		while ((tmr ? timer_interrupt_clock : cpu_clock_tick) !== 1'b1) @(posedge hclk);
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while ((tmr ? timer_interrupt_clock : cpu_clock_tick) !== 1'b1 && n < 100);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task reset_values;
		bus(1'b0, 12'h02C, 32'h0);
		check(q, 32'h7F);
		check(hresp, 1'b0);
		bus(1'b0, 12'h004, 32'h0);
		check(q, 32'h0);
		bus(1'b0, 12'h008, 32'h0);
		check(q, 32'h0);
		bus(1'b0, 12'h0FC, 32'h0);
		check(q, 32'h0);
		bus(1'b1, 12'h02C, 32'hDC);
		bus(1'b0, 12'h02C, 32'h0);
		check(q, 32'h7F);
	endtask

	task divide_ratios;
		logic [1:0] code [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
		int ratio [4] = '{16, 8, 32, 2};
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b1, 12'h02C, {30'h8, code[i]});
			gap(1'b1);
			gap(1'b1);
			check(n, ratio[i]);
			gap(1'b0);
			check(n, ratio[i]);
		end
	endtask

	task quick_wake;
		bus(1'b1, 12'h004, 32'h08);
		bus(1'b1, 12'h02C, 32'h0);
		bus(1'b1, 12'h018, 32'h1);
		repeat (2) @(posedge hclk);
		check(in_stop, 1'b1);
		check(comparator_enable, 1'b0);
		check(cpu_clock_tick, 1'b0);
		toggle(16'h0104);
		check(in_stop, 1'b1);
		toggle(16'h0008);
		check(in_stop, 1'b0);
		check(device_reset, 1'b0);
		check(comparator_enable, 1'b1);
		check(irq, 1'b0);
		bus(1'b0, 12'h02C, 32'h0);
		check(q, 32'hFF);
		bus(1'b0, 12'h010, 32'h0);
		check(q, 32'h1);
		bus(1'b0, 12'h010, 32'h0);
		check(q, 32'h0);
	endtask

	// Second port wakes with the long reset delay and the interrupt unmasked.
	task delayed_wake;
		bus(1'b1, 12'h014, 32'h3);
		bus(1'b1, 12'h004, 32'h0);
		bus(1'b1, 12'h008, 32'h40);
		bus(1'b1, 12'h02C, 32'h20);
		bus(1'b1, 12'h018, 32'h1);
		toggle(16'h4000);
		check(in_stop, 1'b0);
		check(irq, 1'b1);
		n = 0;
		while (device_reset === 1'b1 && n < 60000)
		begin
			@(posedge hclk);
			n++;
		end
		// The count starts one cycle after the delay output is first seen high.
		check(n, stop_recovery_pkg::wake_delay_cycles - 1);
		bus(1'b0, 12'h010, 32'h0);
		check(q, 32'h1);
		@(posedge hclk);
		check(irq, 1'b0);
	endtask

	task cold_start;
		@(posedge hclk);
		watchdog_reset <= 1'b1;
		@(posedge hclk);
		watchdog_reset <= 1'b0;
		bus(1'b0, 12'h02C, 32'h0);
		check(q, 32'h7F);
		bus(1'b0, 12'h010, 32'h0);
		check(q, 32'h2);
	endtask

	task halt_clocks;
		bus(1'b1, 12'h02C, 32'h3);
		bus(1'b1, 12'h018, 32'h2);
		bus(1'b0, 12'h018, 32'h0);
		check(q, 32'h2);
		n = 0;
		repeat (64)
		begin
			@(posedge hclk);
			if (cpu_clock_tick !== 1'b0)
				n = n + 100;
			if (timer_interrupt_clock === 1'b1)
				n++;
		end
		check(n, 4);
	endtask

	// ----------------------------------------------------------------
	// Run control
	// ----------------------------------------------------------------
	task end_sim;
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial
	begin
		repeat (80000) @(posedge hclk);
		n_errors++;
		end_sim;
	end

	initial
	begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		reset_values;
		divide_ratios;
		quick_wake;
		delayed_wake;
		cold_start;
		halt_clocks;
		end_sim;
	end
endmodule

`default_nettype wire
